// >>> core/psg_pkg.sv
// Constants shared by the port select and pin status bank
package psg_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] PSG_OFS_GPIO_LOW = 8'h1c;
    localparam logic [7:0] PSG_OFS_GPIO_HIGH = 8'h1d;
    localparam logic [7:0] PSG_OFS_ROUTING = 8'h1e;

    // ==========================================================
    // Values after reset
    localparam logic [7:0] PSG_RST_GPIO_LOW = 8'h00;
    localparam logic [7:0] PSG_RST_GPIO_HIGH = 8'h00;
    localparam logic [7:0] PSG_RST_ROUTING = 8'h01;

    // ==========================================================
    // Field positions and masks
    localparam int PSG_BIT_FIRST_PICK = 0;
    localparam int PSG_BIT_SECOND_PICK = 1;
    localparam int PSG_BIT_SEC_ENABLE = 2;
    localparam int PSG_BIT_HIGH_PIN = 8;
    localparam logic [7:0] PSG_MASK_GPIO_LOW = 8'hef;
    localparam logic [7:0] PSG_MASK_ROUTING = 8'h07;

    // ==========================================================
    // Widths and bus addressing
    localparam int PSG_PIN_COUNT = 9;
    localparam int PSG_ID_WIDTH = 7;
    localparam logic [6:0] PSG_SEC_ADDR_STEP = 7'h01;
    localparam int PSG_SYNC_STAGES = 2;

endpackage : psg_pkg

// >>> core/psg_pin_sync.sv
// Two-stage synchroniser for the general-purpose pin levels
module psg_pin_sync
#(
    parameter int WIDTH = 9
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_sync
);
    import psg_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } psg_sync_state_t;

    psg_sync_state_t state_reg;
    psg_sync_state_t state_next;

    // ==========================================================
    // Stage one feeds only stage two
    always_comb
    begin
        state_next = state_reg;
        state_next.stage1 = pin_async;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign pin_sync = state_reg.stage2;

endmodule : psg_pin_sync

// >>> core/psg_port_select.sv
// Pin status registers and primary/secondary address port routing
module psg_port_select
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [psg_pkg::PSG_PIN_COUNT-1:0] pin_level_raw,
    input wire logic [psg_pkg::PSG_PIN_COUNT-1:0] pin_input_direction,
    input wire logic [psg_pkg::PSG_ID_WIDTH-1:0] own_bus_identifier,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [psg_pkg::PSG_ID_WIDTH-1:0] acc_dev_addr,
    input wire logic [7:0] acc_reg_addr,
    input wire logic [7:0] acc_wdata,
    output logic rsp_valid,
    output logic rsp_hit,
    output logic [7:0] rsp_rdata,
    output logic route_first_link_port,
    output logic route_second_link_port,
    output logic route_common,
    output logic route_read_second,
    output logic secondary_address_enable,
    output logic second_port_pick,
    output logic first_port_pick
);
    import psg_pkg::*;

    typedef struct packed {
        logic [7:0] routing;
        logic [7:0] gpio_low;
        logic [7:0] gpio_high;
        logic rsp_valid;
        logic rsp_hit;
        logic [7:0] rsp_rdata;
        logic rt_first;
        logic rt_second;
        logic rt_common;
        logic rt_read_second;
    } psg_state_t;

    psg_state_t state_reg;
    psg_state_t state_next;
    logic [PSG_PIN_COUNT-1:0] pin_level_sync;
    logic [PSG_PIN_COUNT-1:0] pin_seen;
    logic [PSG_ID_WIDTH-1:0] sec_addr;
    logic hit_primary;
    logic hit_secondary;
    logic sec_en;
    logic pick_first;
    logic pick_second;

    // ==========================================================
    // Pin synchroniser
    psg_pin_sync #(
        .WIDTH(PSG_PIN_COUNT)
    ) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .pin_async(pin_level_raw),
        .pin_sync(pin_level_sync)
    );

    // ==========================================================
    // Address decode
    assign sec_en = state_reg.routing[PSG_BIT_SEC_ENABLE];
    assign pick_first = state_reg.routing[PSG_BIT_FIRST_PICK];
    assign pick_second = state_reg.routing[PSG_BIT_SECOND_PICK];
    assign sec_addr = own_bus_identifier + PSG_SEC_ADDR_STEP;
    assign hit_primary = acc_dev_addr == own_bus_identifier;
    assign hit_secondary = sec_en && (acc_dev_addr == sec_addr) && !hit_primary;
    // Pins in output mode read as zero
    assign pin_seen = pin_level_sync & pin_input_direction;

    // ==========================================================
    // Next state
    always_comb
    begin
        state_next = state_reg;
        state_next.gpio_low = {pin_seen[7:0]} & PSG_MASK_GPIO_LOW;
        state_next.gpio_high = {7'h00, pin_seen[PSG_BIT_HIGH_PIN]};
        state_next.rsp_valid = acc_valid;
        state_next.rsp_hit = 1'b0;
        state_next.rsp_rdata = 8'h00;
        state_next.rt_first = 1'b0;
        state_next.rt_second = 1'b0;
        state_next.rt_common = 1'b0;
        state_next.rt_read_second = 1'b0;
        if (acc_valid && (hit_primary || hit_secondary))
        begin
            state_next.rsp_hit = 1'b1;
            state_next.rt_common = 1'b1;
            if (hit_secondary)
            begin
                state_next.rt_second = 1'b1;
                state_next.rt_read_second = 1'b1;
            end
            else if (sec_en)
            begin
                state_next.rt_first = 1'b1;
            end
            else if (acc_write)
            begin
                state_next.rt_first = pick_first;
                state_next.rt_second = pick_second;
            end
            else
            begin
                state_next.rt_read_second = pick_second;
                state_next.rt_first = !pick_second;
                state_next.rt_second = pick_second;
            end
            if (acc_write)
            begin
                if (acc_reg_addr == PSG_OFS_ROUTING)
                begin
                    state_next.routing = acc_wdata & PSG_MASK_ROUTING;
                end
            end
            else
            begin
                case (acc_reg_addr)
                    PSG_OFS_GPIO_LOW: state_next.rsp_rdata = state_reg.gpio_low;
                    PSG_OFS_GPIO_HIGH: state_next.rsp_rdata = state_reg.gpio_high;
                    PSG_OFS_ROUTING: state_next.rsp_rdata = state_reg.routing;
                    default: state_next.rsp_rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg.routing <= PSG_RST_ROUTING;
            state_reg.gpio_low <= PSG_RST_GPIO_LOW;
            state_reg.gpio_high <= PSG_RST_GPIO_HIGH;
            state_reg.rsp_valid <= 1'b0;
            state_reg.rsp_hit <= 1'b0;
            state_reg.rsp_rdata <= 8'h00;
            state_reg.rt_first <= 1'b0;
            state_reg.rt_second <= 1'b0;
            state_reg.rt_common <= 1'b0;
            state_reg.rt_read_second <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Outputs
    assign rsp_valid = state_reg.rsp_valid;
    assign rsp_hit = state_reg.rsp_hit;
    assign rsp_rdata = state_reg.rsp_rdata;
    assign route_first_link_port = state_reg.rt_first;
    assign route_second_link_port = state_reg.rt_second;
    assign route_common = state_reg.rt_common;
    assign route_read_second = state_reg.rt_read_second;
    assign secondary_address_enable = state_reg.routing[PSG_BIT_SEC_ENABLE];
    assign second_port_pick = state_reg.routing[PSG_BIT_SECOND_PICK];
    assign first_port_pick = state_reg.routing[PSG_BIT_FIRST_PICK];

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_read(logic [7:0] ofs);
        acc_valid && !acc_write && hit_primary && acc_reg_addr == ofs;
    endsequence

    sequence s_sec_acc;
        acc_valid && hit_secondary;
    endsequence

    sequence s_prim_plain;
        acc_valid && hit_primary && !sec_en;
    endsequence

    a_low_reserved: assert property (s_read(PSG_OFS_GPIO_LOW) |=> rsp_rdata[4] == 1'b0)
        else $error("reserved bit of low pin status not zero");
    a_low_pin_path: assert property (##3 1'b1 |-> state_reg.gpio_low[0] ==
        ($past(pin_level_raw[0], 3) && $past(pin_input_direction[0])))
        else $error("pin 0 level not carried to status");
    a_high_reserved: assert property (s_read(PSG_OFS_GPIO_HIGH) |=> rsp_rdata[7:1] == 7'h00)
        else $error("reserved bits of high pin status not zero");
    a_sec_answer: assert property (acc_valid && sec_en && acc_dev_addr == sec_addr
        |=> rsp_valid && rsp_hit)
        else $error("secondary address not answered");
    a_sec_off: assert property (acc_valid && !sec_en && !hit_primary |=> !rsp_hit)
        else $error("answered a foreign address");
    a_sec_route: assert property (s_sec_acc |=> route_second_link_port && route_common
        && !route_first_link_port && route_read_second)
        else $error("secondary access not routed to second port");
    a_pick_second: assert property (s_prim_plain ##0 acc_write && pick_second
        |=> route_second_link_port && route_common)
        else $error("second pick write not routed");
    a_pick_first: assert property (s_prim_plain ##0 acc_write && pick_first
        |=> route_first_link_port)
        else $error("first pick write not routed");
    a_both_read: assert property (s_prim_plain ##0 !acc_write && pick_second
        |=> route_read_second && !route_first_link_port)
        else $error("read with both picks not from second port");
    a_enable_ignores: assert property ((acc_valid && hit_primary) ##0 sec_en
        |=> route_first_link_port && !route_second_link_port)
        else $error("picks not ignored with secondary enable");
    a_route_reserved: assert property (state_reg.routing[7:3] == 5'h00)
        else $error("reserved routing bits set");

    // A routing write through either matched address lands its low three bits on the next cycle, with bits 7:3 cleared
    sequence s_route_write;
        acc_valid && acc_write && (hit_primary || hit_secondary) && acc_reg_addr == PSG_OFS_ROUTING;
    endsequence

    a_route_write: assert property (s_route_write |=> state_reg.routing[2:0] ==
        $past(acc_wdata[2:0]) && state_reg.routing[7:3] == 5'h00)
        else $error("routing write not applied");

endmodule : psg_port_select

// >>> tb/psg_host_model.sv
// Host model issuing decoded register accesses to the bank
module psg_host_model
(
    input wire logic clk,
    output logic acc_valid,
    output logic acc_write,
    output logic [6:0] acc_dev_addr,
    output logic [7:0] acc_reg_addr,
    output logic [7:0] acc_wdata,
    input wire logic rsp_valid,
    input wire logic rsp_hit,
    input wire logic [7:0] rsp_rdata,
    input wire logic [3:0] route
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        acc_valid = 1'h0;
        acc_write = 1'h0;
        acc_dev_addr = 7'h00;
        acc_reg_addr = 8'h00;
        acc_wdata = 8'h00;
    end

    // ==========================================================
    // Single access: request pulse, answer taken one edge later
    task automatic access(input logic w, input logic [6:0] dev, input logic [7:0] ra,
        input logic [7:0] wd, output logic [5:0] st, output logic [7:0] rd);
        @(posedge clk);
        #1;
        acc_valid = 1'h1;
        acc_write = w;
        acc_dev_addr = dev;
        acc_reg_addr = ra;
        acc_wdata = wd;
        @(posedge clk);
        #1;
        acc_valid = 1'h0;
        // Released lines flip so a stale value is never mistaken for a live one
        acc_write = ~w;
        acc_dev_addr = ~dev;
        acc_reg_addr = ~ra;
        acc_wdata = ~wd;
        st = {rsp_valid, rsp_hit, route};
        rd = rsp_rdata;
    endtask : access
endmodule : psg_host_model

// >>> tb/tb.sv
// Self-checking bench for the port select and pin status bank
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import psg_pkg::*;
    typedef struct packed {
        logic [2:0] op;
        logic [7:0] ra;
        logic [7:0] wd;
        logic hit;
        logic [7:0] rd;
        logic [3:0] rt;
        logic [2:0] pk;
    } psg_row_t;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [8:0] lvl = 9'h1ff;
    logic [8:0] dir = 9'h17f;
    logic [6:0] id = 7'h2a;
    logic acc_valid, acc_write, rsp_valid, rsp_hit, rt_f, rt_s, rt_c, rt_r, sec_en, pk2, pk1;
    logic [6:0] acc_dev_addr;
    logic [7:0] acc_reg_addr, acc_wdata, rsp_rdata, rd;
    logic [5:0] st;
    logic [6:0] d;
    int err_total = 0;
    int total_checks = 0;
    psg_row_t rows [18];

    always #5 clk = ~clk;

    psg_port_select DUT (.clk(clk), .rst(rst), .pin_level_raw(lvl), .pin_input_direction(dir),
        .own_bus_identifier(id), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_dev_addr(acc_dev_addr), .acc_reg_addr(acc_reg_addr), .acc_wdata(acc_wdata),
        .rsp_valid(rsp_valid), .rsp_hit(rsp_hit), .rsp_rdata(rsp_rdata),
        .route_first_link_port(rt_f), .route_second_link_port(rt_s), .route_common(rt_c),
        .route_read_second(rt_r), .secondary_address_enable(sec_en),
        .second_port_pick(pk2), .first_port_pick(pk1));

    psg_host_model host (.clk(clk), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_dev_addr(acc_dev_addr), .acc_reg_addr(acc_reg_addr), .acc_wdata(acc_wdata),
        .rsp_valid(rsp_valid), .rsp_hit(rsp_hit), .rsp_rdata(rsp_rdata),
        .route({rt_f, rt_s, rt_c, rt_r}));

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic final_report;
        $display("Counts: checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    task automatic rd_status(input logic [7:0] ra, output logic [7:0] v);
        host.access(1'h0, id, ra, 8'h00, st, v);
    endtask : rd_status

    // ==========================================================
    // Op field: bit 2 write, bits 1:0 primary, secondary or foreign address
    initial
    begin
        rows = '{
            {3'h0, 8'h1e, 8'h00, 1'h1, 8'h01, 4'ha, 3'h1},
            {3'h0, 8'h1c, 8'h00, 1'h1, 8'h6f, 4'ha, 3'h1},
            {3'h0, 8'h1d, 8'h00, 1'h1, 8'h01, 4'ha, 3'h1},
            {3'h4, 8'h1c, 8'h00, 1'h1, 8'h00, 4'ha, 3'h1},
            {3'h0, 8'h1c, 8'h00, 1'h1, 8'h6f, 4'ha, 3'h1},
            {3'h4, 8'h1e, 8'hff, 1'h1, 8'h00, 4'ha, 3'h7},
            {3'h0, 8'h1e, 8'h00, 1'h1, 8'h07, 4'ha, 3'h7},
            {3'h1, 8'h1e, 8'h00, 1'h1, 8'h07, 4'h7, 3'h7},
            {3'h2, 8'h1e, 8'h00, 1'h0, 8'h00, 4'h0, 3'h7},
            {3'h5, 8'h1e, 8'h03, 1'h1, 8'h00, 4'h7, 3'h3},
            {3'h4, 8'h1e, 8'h03, 1'h1, 8'h00, 4'he, 3'h3},
            {3'h0, 8'h1d, 8'h00, 1'h1, 8'h01, 4'h7, 3'h3},
            {3'h1, 8'h1e, 8'h00, 1'h0, 8'h00, 4'h0, 3'h3},
            {3'h4, 8'h1e, 8'h02, 1'h1, 8'h00, 4'he, 3'h2},
            {3'h0, 8'h1e, 8'h00, 1'h1, 8'h02, 4'h7, 3'h2},
            {3'h4, 8'h1e, 8'h00, 1'h1, 8'h00, 4'h6, 3'h0},
            {3'h0, 8'h1c, 8'h00, 1'h1, 8'h6f, 4'ha, 3'h0},
            {3'h0, 8'h1f, 8'h00, 1'h1, 8'h00, 4'ha, 3'h0}};
        repeat (6) @(posedge clk);
        #1;
        chk("reset picks", {5'h00, sec_en, pk2, pk1}, {5'h00, PSG_RST_ROUTING[2:0]});
        chk("reset valid", {7'h00, rsp_valid}, 8'h00);
        rst = 1'h0;
        repeat (3) @(posedge clk);
        $display("Test reset done");
        foreach (rows[i])
        begin
            d = (rows[i].op[1:0] == 2'h0) ? id : (rows[i].op[0] ? id + 7'h01 : 7'h30);
            host.access(rows[i].op[2], d, rows[i].ra, rows[i].wd, st, rd);
            chk("status", {2'h0, st}, {3'h1, rows[i].hit, rows[i].rt});
            chk("rdata", rd, rows[i].rd);
            chk("picks", {5'h00, sec_en, pk2, pk1}, {5'h00, rows[i].pk});
        end
        $display("Test rows done");
        // Reset in mid-run acts without a clock edge
        #3;
        rst = 1'h1;
        #1;
        chk("async reset", {5'h00, sec_en, pk2, pk1}, {5'h00, PSG_RST_ROUTING[2:0]});
        @(posedge clk);
        #1;
        rst = 1'h0;
        lvl = 9'h1f0;
        dir = 9'h0ff;
        repeat (4) @(posedge clk);
        rd_status(PSG_OFS_GPIO_LOW, rd);
        chk("low pins", rd, 8'he0);
        rd_status(PSG_OFS_GPIO_HIGH, rd);
        chk("high pin", rd, 8'h00);
        $display("Test pins done");
        final_report();
    end

    initial
    begin
        #20us;
        err_total++;
        $display("Watchdog expired");
        final_report();
    end
endmodule : tb
